/* rtl/maskable_interrupt_control.sv */
// Function
// RQ1: each source branches through its own fixed vector entry, 29 sources.
// RQ2: entry takes 14 cycles and ends at the routine's first instruction.
// RQ3: entry saves program counter, accumulator, register base, status word, in order.
// RQ4: entry clears the accepted source's request flag.
// RQ5: entry clears the master enable in the status word.
// RQ6: with priority on, entry blocks levels equal to or below the accepted one.
// RQ7: last entry step loads the program counter from the vector entry.
// RQ8: software ends every routine with the return instruction.
// RQ9: return takes 12 cycles.
// RQ10: return unblocks levels, then restores status word, base, accumulator, counter.
// RQ11: expanded memory also saves code segment; entry 17, return 14 cycles.
// RQ12: nonmaskable and reset processing ignore the cleared master enable.
// RQ13: requests raised while blocked wait; lowest vector goes first.
// RQ14: nesting accepted only from enabled sources once master enable is set.
// RQ15: a disabled source's request stays pending until its enable is set.
// RQ16: with priority on, nest only strictly higher levels than the current routine.
// RQ17: with priority off, every enabled source may nest once master enable is set.
// RQ18: waiting requests served by descending level, then lowest vector.
// RQ19: each source has a selectable three-level priority.
// RQ20: each source owns request, enable and priority bits in separate registers.
// RQ21: master enable zero blocks all; one lets only enabled sources through.
// RQ22: priority flag zero ignores levels; one applies the three-level scheme.
// RQ23: priority bits 00 level 0, 01 level 1, high bit set level 2.
// RQ24: simultaneous equal requests choose the lower vector address.
// RQ25: a request flag stays set until entry or a software write clears it.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module maskable_interrupt_control #(
  parameter int unsigned N = irq_ctl_pkg::NUM_SOURCES
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic [N-1:0]  source_event,
  input  wire logic          rti_start,
  input  wire logic          nmi_pending,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output logic      [15:0]   reg_rdata,
  output logic               entry_busy,
  output logic               return_busy,
  output logic      [2:0]    save_op,
  output logic      [2:0]    restore_op,
  output logic               pc_load,
  output logic      [15:0]   pc_vector,
  output logic               first_instr,
  output logic               master_irq_enable
);
  typedef enum logic [1:0] {IDLE, ENTRY, RETURN} seq_t;
  seq_t           state_reg;
  logic [N-1:0]   request_reg;
  logic [N-1:0]   source_enable_flag;
  logic [N-1:0]   priority_low_bit;
  logic [N-1:0]   priority_high_bit;
  logic           master_priority_enable;
  logic           mem_expanded;
  logic [4:0]     cnt_reg;
  logic [4:0]     win_reg;
  // nesting level stack: bit k set by entry at level k, cleared by the return of any level-k routine
  logic [3:0]     active_lv_reg;
  logic [1:0]     lv_stack_reg [8];
  logic [2:0]     sp_reg;

  ////////////////////////////////////////////////////////////////
  function automatic logic [1:0] decode_level(input logic hi, input logic lo);
    decode_level = hi ? 2'h2 : {1'b0, lo}; // [RQ23]
  endfunction

  function automatic logic [4:0] seq_len(input logic exp, input logic entry);
    if (entry) begin
      seq_len = exp ? irq_ctl_pkg::ENTRY_CYC_EXP : irq_ctl_pkg::ENTRY_CYC; // [RQ2] [RQ11]
    end else begin
      seq_len = exp ? irq_ctl_pkg::RETURN_CYC_EXP : irq_ctl_pkg::RETURN_CYC; // [RQ9] [RQ11]
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // arbitration: level first, then lowest vector index
  logic [1:0] cur_level;
  logic       routine_running;
  logic       win_valid;
  logic [4:0] win_idx;
  logic [1:0] win_lv;
  always_comb begin
    logic [1:0] lv;
    lv = 2'h0;
    cur_level = lv_stack_reg[sp_reg - 3'h1];
    routine_running = (sp_reg != 3'h0);
    win_valid = 1'b0;
    win_idx = 5'h00;
    win_lv = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      lv = decode_level(priority_high_bit[i], priority_low_bit[i]); // [RQ19]
      if (request_reg[i] && source_enable_flag[i]) begin // [RQ15] [RQ21]
        if (!master_priority_enable || !routine_running || lv > cur_level) begin // [RQ16] [RQ17]
          if (!win_valid || !master_priority_enable || lv >= win_lv) begin // [RQ18] [RQ24]
            win_valid = 1'b1;
            win_idx = 5'(i);
            win_lv = lv;
          end
        end
      end
    end
    if (!master_priority_enable) begin
      win_lv = 2'h0; // [RQ22]
    end
  end

  // nonmaskable work always goes first and is never held off by the master enable
  logic accept;
  assign accept = (state_reg == IDLE) && master_irq_enable && win_valid && !nmi_pending
                  && !rti_start; // [RQ12] [RQ13] [RQ14]

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= IDLE;
      cnt_reg <= 5'h00;
      win_reg <= 5'h00;
    end else begin
      case (state_reg)
        IDLE: begin
          cnt_reg <= 5'h00;
          if (rti_start && routine_running) begin // [RQ8]
            state_reg <= RETURN;
            cnt_reg <= 5'h01;
          end else if (accept) begin
            state_reg <= ENTRY;
            cnt_reg <= 5'h01;
            win_reg <= win_idx;
          end
        end
        ENTRY: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == seq_len(mem_expanded, 1'b1)) begin // [RQ2]
            state_reg <= IDLE;
          end
        end
        default: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == seq_len(mem_expanded, 1'b0)) begin // [RQ9]
            state_reg <= IDLE;
          end
        end
      endcase
    end
  end

  // sequencer outputs, one step code per cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      save_op <= irq_ctl_pkg::OP_NONE;
      restore_op <= irq_ctl_pkg::OP_NONE;
      pc_load <= 1'b0;
      pc_vector <= 16'h0000;
      first_instr <= 1'b0;
      entry_busy <= 1'b0;
      return_busy <= 1'b0;
    end else begin
      save_op <= irq_ctl_pkg::OP_NONE;
      restore_op <= irq_ctl_pkg::OP_NONE;
      pc_load <= 1'b0;
      first_instr <= 1'b0;
      entry_busy <= (state_reg == ENTRY) && (cnt_reg != seq_len(mem_expanded, 1'b1));
      return_busy <= (state_reg == RETURN) && (cnt_reg != seq_len(mem_expanded, 1'b0));
      if (state_reg == ENTRY) begin
        if (cnt_reg == irq_ctl_pkg::STEP_PC) save_op <= irq_ctl_pkg::OP_PC; // [RQ3]
        if (cnt_reg == irq_ctl_pkg::STEP_ACC) save_op <= irq_ctl_pkg::OP_ACC; // [RQ3]
        if (cnt_reg == irq_ctl_pkg::STEP_LRB) save_op <= irq_ctl_pkg::OP_LRB; // [RQ3]
        if (cnt_reg == irq_ctl_pkg::STEP_PSW) save_op <= irq_ctl_pkg::OP_PSW; // [RQ3]
        if (mem_expanded && cnt_reg == irq_ctl_pkg::STEP_CSR) begin
          save_op <= irq_ctl_pkg::OP_CSR; // [RQ11]
        end
        if (cnt_reg == seq_len(mem_expanded, 1'b1) - 5'h01) begin
          pc_load <= 1'b1; // [RQ7]
          pc_vector <= irq_ctl_pkg::VECTORS[win_reg]; // [RQ1]
        end
        if (cnt_reg == seq_len(mem_expanded, 1'b1)) first_instr <= 1'b1; // [RQ2]
      end
      if (state_reg == RETURN) begin
        if (cnt_reg == irq_ctl_pkg::STEP_PC) restore_op <= irq_ctl_pkg::OP_PSW; // [RQ10]
        if (cnt_reg == irq_ctl_pkg::STEP_ACC) restore_op <= irq_ctl_pkg::OP_LRB; // [RQ10]
        if (cnt_reg == irq_ctl_pkg::STEP_LRB) restore_op <= irq_ctl_pkg::OP_ACC; // [RQ10]
        if (cnt_reg == irq_ctl_pkg::STEP_PSW) restore_op <= irq_ctl_pkg::OP_PC; // [RQ10]
        if (mem_expanded && cnt_reg == irq_ctl_pkg::STEP_CSR) begin
          restore_op <= irq_ctl_pkg::OP_CSR; // [RQ11]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // level stack: push at entry, pop first thing on return
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sp_reg <= 3'h0;
      active_lv_reg <= 4'h0;
      for (int k = 0; k < 8; k++) lv_stack_reg[k] <= 2'h0;
    end else begin
      if (accept) begin
        lv_stack_reg[sp_reg] <= win_lv; // [RQ6]
        sp_reg <= sp_reg + 3'h1;
        active_lv_reg[win_lv] <= 1'b1;
      end else if (state_reg == IDLE && rti_start && routine_running) begin
        sp_reg <= sp_reg - 3'h1; // [RQ10]
        active_lv_reg[cur_level] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // request flags: events win over any clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      request_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (source_event[i]) begin
          request_reg[i] <= 1'b1; // [RQ25]
        end else if (accept && win_idx == 5'(i)) begin
          request_reg[i] <= 1'b0; // [RQ4]
        end else if (reg_write && reg_addr == irq_ctl_pkg::REQ_LO_OFS && i < 16) begin
          request_reg[i] <= reg_wdata[i % 16]; // [RQ20] [RQ25]
        end else if (reg_write && reg_addr == irq_ctl_pkg::REQ_HI_OFS && i >= 16) begin
          request_reg[i] <= reg_wdata[i % 16]; // [RQ25]
        end
      end
    end
  end

  // master enable: cleared by entry, set by return, writable by software
  always_ff @(posedge clock) begin
    if (!nrst) begin
      master_irq_enable <= 1'b0;
    end else if (accept) begin
      master_irq_enable <= 1'b0; // [RQ5]
    end else if (state_reg == RETURN && cnt_reg == irq_ctl_pkg::STEP_PC) begin
      master_irq_enable <= 1'b1; // [RQ10]
    end else if (reg_write && reg_addr == irq_ctl_pkg::CTRL_OFS) begin
      master_irq_enable <= reg_wdata[irq_ctl_pkg::CTRL_MIE_BIT]; // [RQ14]
    end
  end

  ////////////////////////////////////////////////////////////////
  // register port
  function automatic logic [15:0] pad(input logic [N-1:0] v, input logic hi);
    logic [31:0] w;
    w = 32'(v);
    pad = hi ? w[31:16] : w[15:0];
  endfunction

  always_ff @(posedge clock) begin
    if (!nrst) begin
      source_enable_flag <= '0;
      priority_low_bit <= '0;
      priority_high_bit <= '0;
      master_priority_enable <= 1'b0;
      mem_expanded <= 1'b0;
    end else if (reg_write) begin
      for (int i = 0; i < N; i++) begin
        if (reg_addr == (i < 16 ? irq_ctl_pkg::EN_LO_OFS : irq_ctl_pkg::EN_HI_OFS)) begin
          source_enable_flag[i] <= reg_wdata[i % 16]; // [RQ20]
        end
        if (reg_addr == (i < 16 ? irq_ctl_pkg::PRI_LO_OFS : irq_ctl_pkg::PRI_HI_OFS)) begin
          priority_low_bit[i] <= reg_wdata[i % 16]; // [RQ19]
        end
        if (reg_addr == (i < 16 ? irq_ctl_pkg::PRIH_LO_OFS : irq_ctl_pkg::PRIH_HI_OFS)) begin
          priority_high_bit[i] <= reg_wdata[i % 16]; // [RQ19]
        end
      end
      if (reg_addr == irq_ctl_pkg::CTRL_OFS) begin
        master_priority_enable <= reg_wdata[irq_ctl_pkg::CTRL_MASTER_PRIORITY_ENABLE_BIT]; // [RQ22]
        mem_expanded <= reg_wdata[irq_ctl_pkg::CTRL_EXP_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= irq_ctl_pkg::REG_RESET;
    end else if (!reg_read) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == irq_ctl_pkg::REQ_LO_OFS) begin
      reg_rdata <= pad(request_reg, 1'b0);
    end else if (reg_addr == irq_ctl_pkg::REQ_HI_OFS) begin
      reg_rdata <= pad(request_reg, 1'b1);
    end else if (reg_addr == irq_ctl_pkg::EN_LO_OFS) begin
      reg_rdata <= pad(source_enable_flag, 1'b0);
    end else if (reg_addr == irq_ctl_pkg::EN_HI_OFS) begin
      reg_rdata <= pad(source_enable_flag, 1'b1);
    end else if (reg_addr == irq_ctl_pkg::PRI_LO_OFS) begin
      reg_rdata <= pad(priority_low_bit, 1'b0);
    end else if (reg_addr == irq_ctl_pkg::PRI_HI_OFS) begin
      reg_rdata <= pad(priority_low_bit, 1'b1);
    end else if (reg_addr == irq_ctl_pkg::PRIH_LO_OFS) begin
      reg_rdata <= pad(priority_high_bit, 1'b0);
    end else if (reg_addr == irq_ctl_pkg::PRIH_HI_OFS) begin
      reg_rdata <= pad(priority_high_bit, 1'b1);
    end else if (reg_addr == irq_ctl_pkg::CTRL_OFS) begin
      reg_rdata <= {13'h0000, mem_expanded, master_priority_enable, master_irq_enable};
    end else if (reg_addr == irq_ctl_pkg::STAT_OFS) begin
      reg_rdata <= {3'h0, win_reg, 1'b0, sp_reg, active_lv_reg};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  chk_entry_len: assert property (@(posedge clock) disable iff (!nrst) // [RQ2]
    (accept && !mem_expanded) |=> (state_reg == ENTRY && cnt_reg == 5'h01) ##13
    (state_reg == ENTRY && cnt_reg == irq_ctl_pkg::ENTRY_CYC) ##1 (state_reg == IDLE))
    else $error("entry length wrong");
  chk_return_len: assert property (@(posedge clock) disable iff (!nrst) // [RQ9]
    (state_reg == IDLE && rti_start && routine_running && !mem_expanded)
    |=> (state_reg == RETURN && cnt_reg == 5'h01) ##11
    (state_reg == RETURN && cnt_reg == irq_ctl_pkg::RETURN_CYC) ##1 (state_reg == IDLE))
    else $error("return length wrong");
  chk_mie_clear: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
    accept |=> !master_irq_enable)
    else $error("master enable not cleared");
  chk_req_clear: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
    (accept && !source_event[win_idx]) |=> !request_reg[win_reg])
    else $error("request not cleared");
  chk_vector_load: assert property (@(posedge clock) disable iff (!nrst) // [RQ7]
    pc_load |-> pc_vector == irq_ctl_pkg::VECTORS[win_reg] ##1 first_instr)
    else $error("vector load wrong");
  chk_save_order: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
    accept |=> ##1 save_op == irq_ctl_pkg::OP_PC ##1 save_op == irq_ctl_pkg::OP_ACC
    ##1 save_op == irq_ctl_pkg::OP_LRB ##1 save_op == irq_ctl_pkg::OP_PSW)
    else $error("save order wrong");
  chk_mie_block: assert property (@(posedge clock) disable iff (!nrst) // [RQ21]
    !master_irq_enable |-> !accept)
    else $error("accepted while masked");
  chk_hold_flag: assert property (@(posedge clock) disable iff (!nrst) // [RQ25]
    (request_reg != '0 && !accept && !reg_write) |=> ((request_reg & $past(request_reg))
    == $past(request_reg)))
    else $error("request dropped");
  chk_nest_level: assert property (@(posedge clock) disable iff (!nrst) // [RQ16]
    (accept && master_priority_enable && routine_running) |-> win_lv > cur_level)
    else $error("nested at low level");
  cov_entry: cover property (@(posedge clock) disable iff (!nrst) accept);
  cov_nested: cover property (@(posedge clock) disable iff (!nrst) accept && routine_running);
  cov_return: cover property (@(posedge clock) disable iff (!nrst) state_reg == RETURN);
endmodule

/* rtl/irq_ctl_pkg.sv */
package irq_ctl_pkg;
  localparam int unsigned NUM_SOURCES = 29;
  localparam int unsigned CLK_HZ      = 20000000;
  // register offsets (word index on the plain port)
  localparam logic [3:0] REQ_LO_OFS   = 4'h0;
  localparam logic [3:0] REQ_HI_OFS   = 4'h1;
  localparam logic [3:0] EN_LO_OFS    = 4'h2;
  localparam logic [3:0] EN_HI_OFS    = 4'h3;
  localparam logic [3:0] PRI_LO_OFS   = 4'h4;
  localparam logic [3:0] PRI_HI_OFS   = 4'h5;
  localparam logic [3:0] PRIH_LO_OFS  = 4'h6;
  localparam logic [3:0] PRIH_HI_OFS  = 4'h7;
  localparam logic [3:0] CTRL_OFS     = 4'h8;
  localparam logic [3:0] STAT_OFS     = 4'h9;
  // control register fields
  localparam int unsigned CTRL_MIE_BIT  = 0;
  localparam int unsigned CTRL_MASTER_PRIORITY_ENABLE_BIT = 1;
  localparam int unsigned CTRL_EXP_BIT  = 2;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  // hardware sequence lengths in cycles
  localparam logic [4:0] ENTRY_CYC      = 5'h0E;
  localparam logic [4:0] RETURN_CYC     = 5'h0C;
  localparam logic [4:0] ENTRY_CYC_EXP  = 5'h11;
  localparam logic [4:0] RETURN_CYC_EXP = 5'h0E;
  // save/restore step positions inside a sequence
  localparam logic [4:0] STEP_PC   = 5'h01;
  localparam logic [4:0] STEP_ACC  = 5'h02;
  localparam logic [4:0] STEP_LRB  = 5'h03;
  localparam logic [4:0] STEP_PSW  = 5'h04;
  localparam logic [4:0] STEP_CSR  = 5'h05;
  // vector table entries, lowest first
  localparam logic [15:0] VECTORS [NUM_SOURCES] = '{
    16'h000A, 16'h000C, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020,
    16'h0022, 16'h0024, 16'h0026, 16'h002A, 16'h002C, 16'h002E, 16'h0030, 16'h0036,
    16'h0038, 16'h003A, 16'h003C, 16'h003E, 16'h0040, 16'h0042, 16'h0044, 16'h0048,
    16'h006A, 16'h006C, 16'h006E, 16'h0070, 16'h0072};
  // save/restore step codes on the sequencer port
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_PC   = 3'h1;
  localparam logic [2:0] OP_ACC  = 3'h2;
  localparam logic [2:0] OP_LRB  = 3'h3;
  localparam logic [2:0] OP_PSW  = 3'h4;
  localparam logic [2:0] OP_CSR  = 3'h5;
endpackage

/* test/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       first_instr,
  input  wire logic       entry_busy,
  input  wire logic       return_busy,
  input  wire logic       hold,
  input  wire logic [3:0] delay,
  output logic            rti_start
);
  int unsigned depth;
  logic [3:0]  cnt_reg;
  logic        go_reg = 1'b0;
  logic        gap_reg = 1'b0;
  ////////////////////////////////////////
  // routine body stands in for software; hold keeps a routine open for nesting
  assign rti_start = go_reg;
  always @(posedge clock) begin
    go_reg <= 1'b0;
    gap_reg <= go_reg;
    if (!nrst) begin
      depth   <= 0;
      cnt_reg <= 4'h0;
    end else if (first_instr) begin
      depth   <= depth + 1;
      cnt_reg <= 4'h0;
    end else if (depth != 0 && !hold && !entry_busy && !return_busy && !go_reg && !gap_reg) begin
      // return only while idle, else it would be ignored
      // busy shows a cycle late, so two cycles pass after each return pulse
      if (cnt_reg >= delay) begin
        go_reg  <= 1'b1;
        depth   <= depth - 1;
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic        clock = 1'b0;
  logic        nrst;
  logic [28:0] source_event;
  logic        nmi_pending, reg_write, reg_read, hold, rti_start;
  logic [3:0]  reg_addr, delay;
  logic [15:0] reg_wdata, reg_rdata, pc_vector;
  logic        entry_busy, return_busy, pc_load, first_instr, master_irq_enable;
  logic [2:0]  save_op, restore_op;
  int          fails = 0;
  int          n_tests = 0;
  int          a, b, c, i;

  maskable_interrupt_control dut (.clock(clock), .nrst(nrst), .source_event(source_event),
    .rti_start(rti_start), .nmi_pending(nmi_pending), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .entry_busy(entry_busy), .return_busy(return_busy),
    .save_op(save_op), .restore_op(restore_op), .pc_load(pc_load),
    .pc_vector(pc_vector), .first_instr(first_instr),
    .master_irq_enable(master_irq_enable));
  cpu_model partner (.clock(clock), .nrst(nrst), .first_instr(first_instr),
    .entry_busy(entry_busy), .return_busy(return_busy), .hold(hold), .delay(delay),
    .rti_start(rti_start));

  always #25 clock = ~clock;
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  task automatic set29(input logic [3:0] ad, input logic [28:0] m);
    wr(ad, m[15:0]);
    wr(ad + 4'h1, {3'h0, m[28:16]});
  endtask

  // stale flags are cleared first so each test starts from known requests
  task automatic cfg(input logic [28:0] en, input logic [28:0] lo, input logic [28:0] hi,
                     input logic [15:0] ctl);
    set29(irq_ctl_pkg::REQ_LO_OFS, 29'h0);
    set29(irq_ctl_pkg::EN_LO_OFS, en);
    set29(irq_ctl_pkg::PRI_LO_OFS, lo);
    set29(irq_ctl_pkg::PRIH_LO_OFS, hi);
    wr(irq_ctl_pkg::CTRL_OFS, ctl);
  endtask

  task automatic ev(input logic [28:0] m);
    @(posedge clock);
    source_event <= m;
    @(posedge clock);
    source_event <= 29'h0;
  endtask

  task automatic req_bit(input int k, input logic e);
    logic [15:0] d;
    rd(irq_ctl_pkg::REQ_LO_OFS + ((k > 15) ? 4'h1 : 4'h0), d);
    `CHK(d[k % 16], e)
  endtask

  function automatic logic [14:0] seq(input logic ret, input logic x);
    logic [14:0] s;
    s = ret ? {3'h0, irq_ctl_pkg::OP_PSW, irq_ctl_pkg::OP_LRB, irq_ctl_pkg::OP_ACC,
               irq_ctl_pkg::OP_PC}
            : {3'h0, irq_ctl_pkg::OP_PC, irq_ctl_pkg::OP_ACC, irq_ctl_pkg::OP_LRB,
               irq_ctl_pkg::OP_PSW};
    if (x) s = {s[11:0], irq_ctl_pkg::OP_CSR};
    return s;
  endfunction

  task automatic wait_busy(input logic ret);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (((ret ? return_busy : entry_busy) !== 1'b1) && n < 400);
    if (n >= 400) begin
      `CHK(1'b0, 1'b1)
      close_out();
    end
  endtask

  task automatic no_entry(input int n);
    repeat (n) begin
      @(negedge clock);
      `CHK(entry_busy, 1'b0)
    end
  endtask

  task automatic entry_chk(input int k, input logic x);
    logic [14:0] s;
    logic [15:0] v;
    int          n, pl;
    s = 15'h0;
    v = 16'h0;
    // busy is registered: the first sequence cycle is past when it shows
    n = 1;
    pl = -1;
    wait_busy(1'b0);
    `CHK(master_irq_enable, 1'b0)
    while (first_instr !== 1'b1 && n < 40) begin
      if (save_op !== 3'h0) s = {s[11:0], save_op};
      if (pc_load === 1'b1) begin
        v = pc_vector;
        pl = n;
      end
      @(negedge clock);
      n++;
    end
    `CHK(n, x ? 17 : 14)
    `CHK(pl, n - 1)
    `CHK(v, irq_ctl_pkg::VECTORS[k])
    `CHK(s, seq(1'b0, x))
    req_bit(k, 1'b0);
  endtask

  task automatic return_chk(input logic x);
    logic [14:0] s;
    logic        m;
    int          n;
    s = 15'h0;
    m = 1'b0;
    n = 1;
    wait_busy(1'b1);
    while (return_busy === 1'b1 && n < 40) begin
      if (restore_op !== 3'h0) s = {s[11:0], restore_op};
      if (n == 2) m = master_irq_enable;
      @(negedge clock);
      n++;
    end
    `CHK(n, x ? 14 : 12)
    `CHK(s, seq(1'b1, x))
    `CHK(m, 1'b1)
  endtask

  task automatic isr(input int k);
    entry_chk(k, 1'b0);
    return_chk(1'b0);
  endtask

  task automatic pick3();
    a = $urandom % 27;
    b = a + 1 + $urandom % (27 - a);
    c = b + 1 + $urandom % (28 - b);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [15:0] d;
    logic        x;
    {source_event, nmi_pending, reg_write, reg_read, hold} = '0;
    {reg_addr, reg_wdata, nrst} = '0;
    delay = 4'h2;
    i = $urandom(67);
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    wr(4'hF, 16'hFFFF);
    for (int k = 0; k < 11; k++) begin
      rd((k == 10) ? 4'hF : 4'(k), d);
      `CHK(d, 16'h0000)
    end
    $display("test reset done");
    for (int t = 0; t < 12; t++) begin
      i = (t == 0) ? 18 : (t == 1) ? 28 : (t == 2) ? 0 : int'($urandom % 29);
      x = (t > 2) ? 1'($urandom) : 1'b0;
      delay <= 4'($urandom);
      cfg('1, 29'h0, 29'h0, {13'h0, x, 2'b01});
      ev(29'h1 << i);
      entry_chk(i, x);
      if (t < 2) `CHK(pc_vector, (t == 0) ? 16'h003C : 16'h0072)
      return_chk(x);
    end
    $display("test single done");
    for (int p = 0; p < 2; p++) begin
      pick3();
      cfg('1, (29'h1 << b) | (29'h1 << c), 29'h1 << c, {14'h0, p[0], 1'b0});
      ev((29'h1 << a) | (29'h1 << b) | (29'h1 << c));
      no_entry(10);
      req_bit(c, 1'b1);
      wr(irq_ctl_pkg::CTRL_OFS, {14'h0, p[0], 1'b1});
      if (p) begin
        isr(c);
        isr(b);
        isr(a);
      end else begin
        isr(a);
        isr(b);
        isr(c);
      end
    end
    $display("test order done");
    cfg(29'h0, 29'h0, 29'h0, 16'h0001);
    i = $urandom % 29;
    ev(29'h1 << i);
    no_entry(10);
    @(posedge clock);
    nmi_pending <= 1'b1;
    set29(irq_ctl_pkg::EN_LO_OFS, 29'h1 << i);
    no_entry(10);
    @(posedge clock);
    nmi_pending <= 1'b0;
    isr(i);
    $display("test masked done");
    for (int p = 0; p < 2; p++) begin
      pick3();
      cfg('1, (29'h1 << a) | (29'h1 << b) | (29'h1 << c), 29'h1 << c, {14'h0, p[0], 1'b1});
      @(posedge clock);
      hold <= 1'b1;
      ev(29'h1 << a);
      entry_chk(a, 1'b0);
      wr(irq_ctl_pkg::CTRL_OFS, {14'h0, p[0], 1'b1});
      ev(29'h1 << b);
      if (p) begin
        no_entry(20);
        ev(29'h1 << c);
        entry_chk(c, 1'b0);
      end else begin
        entry_chk(b, 1'b0);
      end
      @(posedge clock);
      hold <= 1'b0;
      return_chk(1'b0);
      return_chk(1'b0);
      if (p) isr(b);
    end
    $display("test nesting done");
    close_out();
  end
endmodule
